// File: core/slow_clock_pkg.sv
// Constants and types for the slow clock source manager.
// Assumes a byte-wide special function register port on the CPU clock.
package slow_clock_pkg;

    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_EXT_INT_FLAGS = 8'h91;
    localparam logic [7:0] ADDR_POWER_MGMT = 8'hc4;
    localparam logic [7:0] ADDR_ACTIVITY_STATUS = 8'hc5;

    // Field positions in extended_interrupt_flags
    localparam int SRC_SEL_BIT = 3;
    localparam int RING_FLAG_BIT = 2;

    // Field positions in power_management_control
    localparam int DIV_HI_BIT = 7;
    localparam int DIV_LO_BIT = 6;
    localparam int AUTO_RET_BIT = 5;
    localparam int XTAL_OFF_BIT = 3;

    // Field positions in activity_status
    localparam int PF_ACTIVE_BIT = 7;
    localparam int HIGH_ACTIVE_BIT = 6;
    localparam int LOW_ACTIVE_BIT = 5;
    localparam int XTAL_READY_BIT = 4;
    localparam int TX_BUSY_BIT = 1;
    localparam int RX_BUSY_BIT = 0;

    // Divider codes: input clocks per instruction cycle
    typedef enum logic [1:0] {
        DIV_RSVD = 2'h0,
        DIV_4 = 2'h1,
        DIV_64 = 2'h2,
        DIV_1024 = 2'h3
    } divider_t;

    // Input clocks per cycle for each divider
    localparam int CLOCKS_DIV_4 = 4;
    localparam int CLOCKS_DIV_64 = 64;
    localparam int CLOCKS_DIV_1024 = 1024;

    // Reset values
    localparam divider_t DIV_RESET = DIV_4;
    localparam logic SRC_SEL_RESET = 1'b1;
    localparam logic AUTO_RET_RESET = 1'b0;
    localparam logic XTAL_OFF_RESET = 1'b0;
    localparam logic XTAL_READY_RESET = 1'b1;

    // Crystal warm-up interval in crystal clocks
    localparam int XTAL_WARMUP_CLOCKS = 65536;

endpackage

// File: core/machine_cycle_divider.sv
// Machine cycle tick generator: one pulse per instruction cycle.
// Assumes the divider code is stable between ticks except on switchback.
module machine_cycle_divider
    import slow_clock_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire slow_clock_pkg::divider_t divider_i,
    output logic cycle_tick_o
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] last;

    // Terminal count; a reserved code never reaches here, treated as 4
    always_comb begin
        unique case (divider_i)
            DIV_64: last = CNT_W'(CLOCKS_DIV_64 - 1);
            DIV_1024: last = CNT_W'(CLOCKS_DIV_1024 - 1);
            default: last = CNT_W'(CLOCKS_DIV_4 - 1);
        endcase
    end

    // Free-running count; >= lets a shortened divider end a long cycle at once
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= '0;
        end else if (count >= last) begin
            count <= '0;
        end else begin
            count <= count + CNT_W'(1);
        end
    end

    assign cycle_tick_o = (count >= last);

endmodule

// File: core/slow_clock_source_manager.sv
// Slow clock source manager: divider, crystal/ring choice, switchback,
// write protection and crystal warm-up, behind three byte registers.
// Assumes the CPU core drives the register port and interrupt state
// on this same clock; all inputs are already synchronous.
module slow_clock_source_manager
    import slow_clock_pkg::*;
#(
    parameter int WARMUP_CYCLES = slow_clock_pkg::XTAL_WARMUP_CLOCKS,
    parameter int WARM_W = 17
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic ext_int_pending_i,
    input wire logic ext_int_high_prio_i,
    input wire logic powerfail_level_active_i,
    input wire logic high_level_active_i,
    input wire logic low_level_active_i,
    input wire logic serial0_rx_enable_i,
    input wire logic serial0_start_edge_i,
    input wire logic serial0_rx_busy_i,
    input wire logic serial0_tx_busy_i,
    output logic cycle_tick_o,
    output logic ring_select_o,
    output logic crystal_amp_disable_o
);
    import slow_clock_pkg::*;

    divider_t div_field;
    divider_t div_active;
    logic auto_return_enable;
    logic clock_source_select;
    logic ring_active_flag;
    logic crystal_amp_disable;
    logic crystal_ready_flag;
    logic start_seen;
    logic [WARM_W-1:0] warm_count;
    logic [7:0] next_rdata;

    logic wr_pmr;
    logic wr_extended_interrupt_flags;
    logic serviceable_int;
    logic switchback;
    logic serial_lock;
    divider_t wr_div;
    logic div_write_ok;
    logic src_write_ok;
    logic xoff_write_ok;

    // Write address decode for the two writable registers
    assign wr_pmr = sfr_wr_i && (sfr_addr_i == ADDR_POWER_MGMT);
    assign wr_extended_interrupt_flags = sfr_wr_i && (sfr_addr_i == ADDR_EXT_INT_FLAGS);
    assign wr_div = divider_t'({sfr_wdata_i[DIV_HI_BIT], sfr_wdata_i[DIV_LO_BIT]});

    // Interrupt could really be taken: no equal or higher level in service
    assign serviceable_int = ext_int_pending_i && !powerfail_level_active_i
        && !high_level_active_i && (ext_int_high_prio_i || !low_level_active_i);

    // Auto return events; start edge needs the receiver enabled
    assign switchback = auto_return_enable && (serviceable_int
        || (serial0_start_edge_i && serial0_rx_enable_i));

    // UART activity locks out reduced rates
    assign serial_lock = serial0_rx_busy_i || serial0_tx_busy_i
        || (auto_return_enable && start_seen);

    // Divider write gating: reserved code ignored, slow codes only while running at 4;
    // checking the active divider too stops 64 -> 4 -> 1024 before the 4 took hold
    always_comb begin
        unique case (wr_div)
            DIV_RSVD: div_write_ok = 1'b0;
            DIV_4: div_write_ok = 1'b1;
            default: div_write_ok = (div_field == DIV_4) && (div_active == DIV_4)
                && !serial_lock;
        endcase
    end

    assign src_write_ok = !sfr_wdata_i[SRC_SEL_BIT]
        || (crystal_ready_flag && !crystal_amp_disable);
    assign xoff_write_ok = !sfr_wdata_i[XTAL_OFF_BIT] || !clock_source_select;

    // Start bit memory: held until the receiver goes idle, set wins
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_seen <= 1'b0;
        end else if (serial0_start_edge_i) begin
            start_seen <= 1'b1;
        end else if (!serial0_rx_busy_i) begin
            start_seen <= 1'b0;
        end
    end

    // Divider field; switchback overrides any write in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_field <= DIV_RESET;
        end else if (switchback) begin
            div_field <= DIV_4;
        end else if (wr_pmr && div_write_ok) begin
            div_field <= wr_div;
        end
    end

    // Active divider follows the field at the next cycle boundary
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_active <= DIV_RESET;
        end else if (switchback) begin
            div_active <= DIV_4;
        end else if (cycle_tick_o) begin
            div_active <= div_field;
        end
    end

    // Auto return enable is an unrestricted control bit
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            auto_return_enable <= AUTO_RET_RESET;
        end else if (wr_pmr) begin
            auto_return_enable <= sfr_wdata_i[AUTO_RET_BIT];
        end
    end

    // Crystal amplifier control
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crystal_amp_disable <= XTAL_OFF_RESET;
        end else if (wr_pmr && xoff_write_ok) begin
            crystal_amp_disable <= sfr_wdata_i[XTAL_OFF_BIT];
        end
    end

    // Source select; switchback leaves it alone
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clock_source_select <= SRC_SEL_RESET;
        end else if (wr_extended_interrupt_flags && src_write_ok) begin
            clock_source_select <= sfr_wdata_i[SRC_SEL_BIT];
        end
    end

    // Clock actually in use changes only on a cycle boundary
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ring_active_flag <= !SRC_SEL_RESET;
        end else if (cycle_tick_o) begin
            ring_active_flag <= !clock_source_select;
        end
    end

    // Warm-up: ready drops while off, counts after restart
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            warm_count <= '0;
            crystal_ready_flag <= XTAL_READY_RESET;
        end else if (crystal_amp_disable) begin
            warm_count <= '0;
            crystal_ready_flag <= 1'b0;
        end else if (!crystal_ready_flag) begin
            if (warm_count == WARM_W'(WARMUP_CYCLES - 1)) begin
                crystal_ready_flag <= 1'b1;
            end else begin
                warm_count <= warm_count + WARM_W'(1);
            end
        end
    end

    // Read mux; unused bits read zero, unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (sfr_addr_i)
            ADDR_EXT_INT_FLAGS: begin
                next_rdata[SRC_SEL_BIT] = clock_source_select;
                next_rdata[RING_FLAG_BIT] = ring_active_flag;
            end
            ADDR_POWER_MGMT: begin
                next_rdata[DIV_HI_BIT] = div_field[1];
                next_rdata[DIV_LO_BIT] = div_field[0];
                next_rdata[AUTO_RET_BIT] = auto_return_enable;
                next_rdata[XTAL_OFF_BIT] = crystal_amp_disable;
            end
            ADDR_ACTIVITY_STATUS: begin
                next_rdata[PF_ACTIVE_BIT] = powerfail_level_active_i;
                next_rdata[HIGH_ACTIVE_BIT] = high_level_active_i;
                next_rdata[LOW_ACTIVE_BIT] = low_level_active_i;
                next_rdata[XTAL_READY_BIT] = crystal_ready_flag;
                next_rdata[TX_BUSY_BIT] = serial0_tx_busy_i;
                next_rdata[RX_BUSY_BIT] = serial0_rx_busy_i;
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data registered; holds between reads
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= next_rdata;
        end
    end

    // Same tick serves CPU and timers, whichever source runs
    machine_cycle_divider u_cycle_div (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .divider_i(div_active),
        .cycle_tick_o(cycle_tick_o)
    );

    assign ring_select_o = ring_active_flag;
    assign crystal_amp_disable_o = crystal_amp_disable;

    // Reserved code leaves divider as it was
    chk_reserved_ignored: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_pmr && wr_div == DIV_RSVD && !switchback) |=> $stable(div_field))
        else $error("reserved divider code changed divider");

    // No direct hop from 64 to 1024
    chk_no_direct_slow: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (div_field == DIV_64 && wr_pmr && wr_div == DIV_1024) |=> div_field != DIV_1024)
        else $error("divider went 64 to 1024 directly");

    // Busy serial port keeps the full rate
    chk_serial_protect: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (div_field == DIV_4 && (serial0_rx_busy_i || serial0_tx_busy_i)) |=> div_field == DIV_4)
        else $error("divider slowed during serial activity");

    // Switchback restores 4 clocks on the next edge, source untouched
    chk_switchback_div: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (switchback && !wr_extended_interrupt_flags) |=> (div_field == DIV_4 && div_active == DIV_4
        && clock_source_select == $past(clock_source_select)))
        else $error("switchback did not restore the 4 clock rate");

    // Blocked level gives no switchback
    chk_locked_out: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (high_level_active_i && !serial0_start_edge_i) |-> !switchback)
        else $error("switchback from an unserviceable source");

    // Active divider changes only at a cycle boundary or switchback
    chk_div_delay: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !$stable(div_active) |-> ($past(cycle_tick_o) || $past(switchback)))
        else $error("divider changed mid cycle");

    // Source switch follows the select within one full-rate cycle
    chk_source_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ($fell(clock_source_select) && div_active == DIV_4) |-> ##[1:4] ring_active_flag)
        else $error("ring not taken within one cycle");

    // Crystal select refused before ready
    chk_src_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (!clock_source_select && !crystal_ready_flag) |=> !clock_source_select)
        else $error("crystal selected before ready");

    // Amplifier off only with ring selected
    chk_xoff_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (clock_source_select && !crystal_amp_disable) |=> !crystal_amp_disable)
        else $error("crystal disabled while selected");

    // Ready never shows while the amplifier is off
    chk_ready_off: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        crystal_amp_disable |=> !crystal_ready_flag)
        else $error("crystal ready while amplifier off");

    // Enabled start bit restores 4 clocks on the next edge
    chk_start_return: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (auto_return_enable && serial0_start_edge_i && serial0_rx_enable_i)
        |=> (div_field == DIV_4 && div_active == DIV_4))
        else $error("start bit did not restore the 4 clock rate");

    // Start bit already seen refuses a slow divider write
    chk_start_blocks: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (wr_pmr && auto_return_enable && start_seen && div_field == DIV_4
        && (wr_div == DIV_64 || wr_div == DIV_1024)) |=> div_field == DIV_4)
        else $error("slow divider taken after a start bit");

    // Ring flag moves only at a cycle boundary
    chk_ring_boundary: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !$stable(ring_active_flag) |-> $past(cycle_tick_o))
        else $error("ring flag changed mid cycle");

    // Crystal select is taken within one full-rate cycle
    chk_source_back: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        ($rose(clock_source_select) && div_active == DIV_4) |-> ##[1:4] !ring_active_flag)
        else $error("crystal not taken within one cycle");

endmodule

// File: tb/tb_slow_clock_source_manager.sv
// Self-checking bench for the slow clock source manager.
// Assumes strobes sampled on the rising edge and registered read data; warm-up shortened to 16.
module tb_slow_clock_source_manager;
    timeunit 1ns;
    timeprecision 1ps;
    import slow_clock_pkg::*;

    localparam int WARM = 16;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic pend = 1'b0;
    logic hprio = 1'b0;
    logic pf = 1'b0;
    logic hi = 1'b0;
    logic lo = 1'b0;
    logic rx_en = 1'b0;
    logic start = 1'b0;
    logic rx_busy = 1'b0;
    logic tx_busy = 1'b0;
    logic tick;
    logic ring;
    logic xoff;
    int fails = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h5b7a;
    logic [7:0] got;
    int per;

    slow_clock_source_manager #(.WARMUP_CYCLES(WARM)) slow_clock_source_manager_inst (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
        .ext_int_pending_i(pend), .ext_int_high_prio_i(hprio),
        .powerfail_level_active_i(pf), .high_level_active_i(hi), .low_level_active_i(lo),
        .serial0_rx_enable_i(rx_en), .serial0_start_edge_i(start),
        .serial0_rx_busy_i(rx_busy), .serial0_tx_busy_i(tx_busy),
        .cycle_tick_o(tick), .ring_select_o(ring), .crystal_amp_disable_o(xoff));

    // Free-running 25 MHz clock
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // Repeatable random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic close_out();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe, inputs moved 1 ns after the edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i) #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge sys_clk_i) #1;
        wr = 1'b0;
    endtask

    // Read data is registered at the edge that takes the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i) #1;
        addr = a;
        rd = 1'b1;
        @(posedge sys_clk_i) #1;
        rd = 1'b0;
        d = rdata;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd_reg(a, got);
        check(what, {8'h00, got}, {8'h00, exp});
    endtask

    // Clocks between two ticks; bounded so a stuck divider cannot hang the run
    task automatic measure(output int p);
        int n;
        n = 0;
        p = 0;
        while (tick !== 1'b1 && n < 2100) begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        do begin
            @(posedge sys_clk_i) #1;
            p++;
        end while (tick !== 1'b1 && p < 2100);
        if (n >= 2100 || p >= 2100) begin
            fails++;
            close_out();
        end
    endtask

    task automatic pulse_start(input logic en);
        @(posedge sys_clk_i) #1;
        rx_en = en;
        start = 1'b1;
        @(posedge sys_clk_i) #1;
        start = 1'b0;
        rx_en = 1'b0;
    endtask

    initial begin
        logic [4:0] r;
        repeat (5) @(posedge sys_clk_i);
        #1 rst_b_i = 1'b1;
        // Reset values and an unmapped address
        rd_chk("extended_interrupt_flags reset", ADDR_EXT_INT_FLAGS, 8'h08);
        rd_chk("pmr reset", ADDR_POWER_MGMT, 8'h40);
        rd_chk("status reset", ADDR_ACTIVITY_STATUS, 8'h10);
        rd_chk("unmapped", 8'h00, 8'h00);
        measure(per);
        check("period 4", per[15:0], 16'(CLOCKS_DIV_4));
        // Live status bits under random levels
        for (int i = 0; i < 6; i++) begin
            r = 5'(xs());
            {pf, hi, lo, tx_busy, rx_busy} = r;
            rd_chk("status live", ADDR_ACTIVITY_STATUS, {r[4:2], 3'b100, r[1:0]});
        end
        {pf, hi, lo, tx_busy, rx_busy} = 5'h00;
        // Crystal off refused while crystal selected
        wr_reg(ADDR_POWER_MGMT, 8'h48);
        rd_chk("xoff refused", ADDR_POWER_MGMT, 8'h40);
        check("amp on", {15'h0, xoff}, 16'h0);
        // Divider to 64, then refused direct hop and reserved code
        wr_reg(ADDR_POWER_MGMT, 8'h80);
        rd_chk("div 64", ADDR_POWER_MGMT, 8'h80);
        measure(per);
        measure(per);
        check("period 64", per[15:0], 16'(CLOCKS_DIV_64));
        wr_reg(ADDR_POWER_MGMT, 8'hc0);
        rd_chk("64 to 1024", ADDR_POWER_MGMT, 8'h80);
        wr_reg(ADDR_POWER_MGMT, 8'h20);
        rd_chk("reserved code", ADDR_POWER_MGMT, 8'ha0);
        // Low-priority interrupt locked out by high level in service
        hi = 1'b1;
        pend = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd_chk("locked out", ADDR_POWER_MGMT, 8'ha0);
        hi = 1'b0;
        rd_chk("ext switchback", ADDR_POWER_MGMT, 8'h60);
        pend = 1'b0;
        // Levels in service against the priority of the requesting source
        rd_chk("level check", ADDR_ACTIVITY_STATUS, 8'h10);
        wr_reg(ADDR_POWER_MGMT, 8'ha0);
        lo = 1'b1;
        pend = 1'b1;
        rd_chk("low blocks low", ADDR_POWER_MGMT, 8'ha0);
        {pf, lo, hprio} = 3'b101;
        rd_chk("pf blocks all", ADDR_POWER_MGMT, 8'ha0);
        {pf, lo} = 2'b01;
        rd_chk("high over low", ADDR_POWER_MGMT, 8'h60);
        {pend, hprio, lo} = 3'b000;
        // Start bit returns only with receiver enabled
        wr_reg(ADDR_POWER_MGMT, 8'he0);
        rd_chk("div 1024", ADDR_POWER_MGMT, 8'he0);
        measure(per);
        measure(per);
        check("period 1024", per[15:0], 16'(CLOCKS_DIV_1024));
        pulse_start(1'b0);
        rd_chk("rx off", ADDR_POWER_MGMT, 8'he0);
        pulse_start(1'b1);
        rd_chk("start switchback", ADDR_POWER_MGMT, 8'h60);
        // Start bit just seen blocks a slow write on the next edge
        @(posedge sys_clk_i) #1;
        start = 1'b1;
        @(posedge sys_clk_i) #1;
        start = 1'b0;
        addr = ADDR_POWER_MGMT;
        wdata = 8'ha0;
        wr = 1'b1;
        @(posedge sys_clk_i) #1;
        wr = 1'b0;
        rd_chk("start blocks", ADDR_POWER_MGMT, 8'h60);
        // Serial activity write-protects the divider
        rx_busy = 1'b1;
        wr_reg(ADDR_POWER_MGMT, 8'ha0);
        rd_chk("rx protect", ADDR_POWER_MGMT, 8'h60);
        rx_busy = 1'b0;
        tx_busy = 1'b1;
        wr_reg(ADDR_POWER_MGMT, 8'he0);
        rd_chk("tx protect", ADDR_POWER_MGMT, 8'h60);
        tx_busy = 1'b0;
        // Switch to ring, crystal off, crystal select refused
        wr_reg(ADDR_EXT_INT_FLAGS, 8'h00);
        measure(per);
        rd_chk("ring flag", ADDR_EXT_INT_FLAGS, 8'h04);
        check("ring out", {15'h0, ring}, 16'h1);
        wr_reg(ADDR_POWER_MGMT, 8'h28);
        check("amp off", {15'h0, xoff}, 16'h1);
        rd_chk("not ready", ADDR_ACTIVITY_STATUS, 8'h00);
        wr_reg(ADDR_EXT_INT_FLAGS, 8'h08);
        rd_chk("xtal refused", ADDR_EXT_INT_FLAGS, 8'h04);
        // Ring also divided; switchback keeps the ring
        wr_reg(ADDR_POWER_MGMT, 8'ha8);
        measure(per);
        measure(per);
        check("ring period 64", per[15:0], 16'(CLOCKS_DIV_64));
        pend = 1'b1;
        rd_chk("ring switchback", ADDR_POWER_MGMT, 8'h68);
        pend = 1'b0;
        check("ring kept", {15'h0, ring}, 16'h1);
        // Warm-up then back to the crystal
        wr_reg(ADDR_POWER_MGMT, 8'h20);
        rd_chk("warming", ADDR_ACTIVITY_STATUS, 8'h00);
        repeat (WARM + 4) @(posedge sys_clk_i);
        rd_chk("warm done", ADDR_ACTIVITY_STATUS, 8'h10);
        wr_reg(ADDR_EXT_INT_FLAGS, 8'h08);
        measure(per);
        rd_chk("xtal back", ADDR_EXT_INT_FLAGS, 8'h08);
        check("ring off", {15'h0, ring}, 16'h0);
        close_out();
    end
endmodule
